// ### shared/eeba_defines.svh
// constants for the eeprom byte access block
`ifndef EEBA_DEFINES_SVH
`define EEBA_DEFINES_SVH
`define EEBA_ADDR_W 12
`define EEBA_DEPTH 4096
`define EEBA_OFS_CTRL 6'h1F
`define EEBA_OFS_DATA 6'h20
`define EEBA_OFS_ADDR_LOW 6'h21
`define EEBA_OFS_ADDR_HIGH 6'h22
`define EEBA_HIGH_MASK 8'h0F
`define EEBA_CTRL_READ 0
`define EEBA_CTRL_WRITE 1
`define EEBA_CTRL_MASTER 2
`define EEBA_CTRL_ARMED 3
`define EEBA_ARM_WINDOW 3'h4
`define EEBA_READ_STALL 3'h4
`define EEBA_WRITE_STALL 3'h2
`define EEBA_WRITE_TIME_NS 1000
`define EEBA_WRITE_CYCLES (`EEBA_WRITE_TIME_NS / 10)
`endif

// ### shared/eeba_pkg.sv
// types for the eeprom byte access block
`default_nettype none
package eeba_pkg;
    typedef enum logic [1:0] {
        EEBA_IDLE = 2'b00,
        EEBA_RSTALL = 2'b01,
        EEBA_WSTALL = 2'b10
    } eeba_state_t;
endpackage
`default_nettype wire

// ### shared/eeba_mem_if.sv
// interface between access logic and the storage array
`default_nettype none
interface eeba_mem_if;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    modport ctl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ### design/eeba_array.sv
// byte wide storage array of the eeprom data space
`include "eeba_defines.svh"
`default_nettype none
module eeba_array
    import eeba_pkg::*;
(
    input wire logic i_sys_clk,
    eeba_mem_if.mem mem
);
    logic [7:0] cells [0:`EEBA_DEPTH-1];

    // one byte per access, read registered
    always_ff @(posedge i_sys_clk)
    begin
        if (mem.we)
            cells[mem.addr] <= mem.wdata;
        mem.rdata <= cells[mem.addr];
    end
endmodule
`default_nettype wire

// ### design/eeba_top.sv
// eeprom byte access logic on the processor i/o space
// Behaviour
// - separate byte space, one byte per access
// - address, data, control in i/o space
// - self timed write with busy indication
// - write accepted only after arming procedure
// - read stalls processor four cycles
// - write stalls processor two cycles
// - high address register uses bits 11:8
`include "eeba_defines.svh"
`default_nettype none
module eeba_top
    import eeba_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [5:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    output logic [7:0] o_io_rdata,
    output logic o_cpu_stall,
    output logic o_write_busy
);
    // ----------------------------------------
    // i/o decode
    // ----------------------------------------
    wire sel_ctrl = (i_io_addr == `EEBA_OFS_CTRL);
    wire sel_data = (i_io_addr == `EEBA_OFS_DATA);
    wire sel_low = (i_io_addr == `EEBA_OFS_ADDR_LOW);
    wire sel_high = (i_io_addr == `EEBA_OFS_ADDR_HIGH);

    logic [7:0] addr_low_r;
    logic [3:0] addr_high_r;
    logic [7:0] data_r;
    logic [2:0] arm_cnt_r;
    logic [2:0] stall_cnt_r;
    logic [6:0] wtime_r;
    logic busy_r;
    logic rd_pend_r;
    eeba_state_t state_r;
    eeba_mem_if mif ();

    wire armed = (arm_cnt_r != 3'h0);
    wire idle = (state_r == EEBA_IDLE);
    wire ctrl_wr = i_io_wr && sel_ctrl && idle;
    wire start_rd = ctrl_wr && i_io_wdata[`EEBA_CTRL_READ] && !busy_r;
    // write only while armed and no write in progress
    wire start_wr = ctrl_wr && i_io_wdata[`EEBA_CTRL_WRITE] && armed
        && !busy_r && !start_rd;
    wire arm_wr = ctrl_wr && i_io_wdata[`EEBA_CTRL_MASTER];
    wire [7:0] ctrl_view = {4'h0, armed, 1'b0, busy_r, 1'b0};

    // storage hookup
    assign mif.addr = {addr_high_r, addr_low_r};
    assign mif.wdata = data_r;
    assign mif.we = start_wr;

    eeba_array u_array
    (
        .i_sys_clk(i_sys_clk),
        .mem(mif.mem)
    );

    // ----------------------------------------
    // address and data registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            addr_low_r <= 8'h00;
            addr_high_r <= 4'h0;
        end
        else
        begin
            if (i_io_wr && sel_low && !busy_r)
                addr_low_r <= i_io_wdata;
            if (i_io_wr && sel_high && !busy_r)
                addr_high_r <= i_io_wdata[3:0];
        end
    end

    // data register, loaded by software or by a read
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            data_r <= 8'h00;
        else if (rd_pend_r)
            data_r <= mif.rdata;
        else if (i_io_wr && sel_data && !busy_r)
            data_r <= i_io_wdata;
    end

    // ----------------------------------------
    // arming window for the write procedure
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            arm_cnt_r <= 3'h0;
        else if (arm_wr)
            arm_cnt_r <= `EEBA_ARM_WINDOW;
        else if (armed)
            arm_cnt_r <= arm_cnt_r - 3'h1;
    end

    // ----------------------------------------
    // self timed write
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            busy_r <= 1'b0;
            wtime_r <= 7'h00;
        end
        else if (start_wr)
        begin
            busy_r <= 1'b1;
            wtime_r <= 7'(`EEBA_WRITE_CYCLES - 1);
        end
        else if (busy_r)
        begin
            if (wtime_r == 7'h00)
                busy_r <= 1'b0;
            else
                wtime_r <= wtime_r - 7'h01;
        end
    end

    // ----------------------------------------
    // processor stall sequencer
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r <= EEBA_IDLE;
            stall_cnt_r <= 3'h0;
            rd_pend_r <= 1'b0;
        end
        else
        begin
            rd_pend_r <= start_rd;
            case (state_r)
                EEBA_IDLE:
                begin
                    if (start_rd)
                    begin
                        state_r <= EEBA_RSTALL;
                        stall_cnt_r <= `EEBA_READ_STALL - 3'h1;
                    end
                    else if (start_wr)
                    begin
                        state_r <= EEBA_WSTALL;
                        stall_cnt_r <= `EEBA_WRITE_STALL - 3'h1;
                    end
                end
                EEBA_RSTALL, EEBA_WSTALL:
                begin
                    if (stall_cnt_r == 3'h0)
                        state_r <= EEBA_IDLE;
                    else
                        stall_cnt_r <= stall_cnt_r - 3'h1;
                end
                default:
                    state_r <= EEBA_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    wire stall_nxt = (start_rd || start_wr)
        || (!idle && stall_cnt_r != 3'h0);
    // busy flag tracks the write timer exactly, so it never lags acceptance
    wire busy_nxt = start_wr || (busy_r && wtime_r != 7'h00);
    wire [7:0] rdata_nxt = !i_io_rd ? 8'h00 :
        sel_low ? addr_low_r :
        sel_high ? {4'h0, addr_high_r} :
        sel_data ? data_r :
        sel_ctrl ? ctrl_view : 8'h00;

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_io_rdata <= 8'h00;
            o_cpu_stall <= 1'b0;
            o_write_busy <= 1'b0;
        end
        else
        begin
            o_io_rdata <= rdata_nxt;
            o_cpu_stall <= stall_nxt;
            o_write_busy <= busy_nxt;
        end
    end
endmodule
`default_nettype wire

// ### tb/eeba_top_sva.sv
// assertion checker for the eeprom byte access block
`include "eeba_defines.svh"
`default_nettype none
module eeba_top_sva
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [5:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] o_io_rdata,
    input wire logic o_cpu_stall,
    input wire logic o_write_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // control register write strobe
    wire ctl_wr = i_io_wr && (i_io_addr == `EEBA_OFS_CTRL);
    a_read_stall:
        assert property (ctl_wr && i_io_wdata[0] && !o_cpu_stall && !o_write_busy
            |=> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read stall length");
    a_write_stall:
        assert property ($rose(o_write_busy) |-> o_cpu_stall ##1 o_cpu_stall ##1 !o_cpu_stall)
            else $error("write stall length");
    a_busy_time:
        assert property ($rose(o_write_busy) |-> ##99 o_write_busy ##1 !o_write_busy)
            else $error("write busy length");
    a_busy_cause:
        assert property ($rose(o_write_busy) |-> $past(ctl_wr && i_io_wdata[1]))
            else $error("busy without write start");
    a_stall_cause:
        assert property ($rose(o_cpu_stall) |-> $past(ctl_wr)) else $error("stall without cause");
    a_rdata_idle:
        assert property (!$past(i_io_rd) |-> o_io_rdata == 8'h00) else $error("rdata not zero");
    a_high_zero:
        assert property ($past(i_io_rd && i_io_addr == `EEBA_OFS_ADDR_HIGH)
            |-> o_io_rdata[7:4] == 4'h0) else $error("unused address bits set");
    a_busy_no_read:
        assert property (o_write_busy && ctl_wr && i_io_wdata[0] && !o_cpu_stall
            |=> !o_cpu_stall) else $error("read started while busy");
    // main scenarios
    cover property ($rose(o_write_busy));
    cover property ($fell(o_cpu_stall));
    cover property ($past(i_io_rd) && o_io_rdata != 8'h00);
endmodule
bind eeba_top eeba_top_sva eeba_top_sva_inst (.i_sys_clk, .i_resetn, .i_io_addr,
    .i_io_wdata, .i_io_wr, .i_io_rd, .o_io_rdata, .o_cpu_stall, .o_write_busy);
`default_nettype wire

// ### tb/eeba_cpu_model.sv
// processor core model issuing i/o register accesses
`include "eeba_defines.svh"
`default_nettype none
module eeba_cpu_model
(
    input wire logic i_sys_clk,
    input wire logic [7:0] i_io_rdata,
    output logic [5:0] o_io_addr = 6'h00,
    output logic [7:0] o_io_wdata = 8'h00,
    output logic o_io_wr = 1'b0,
    output logic o_io_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // one write cycle, data inverted once released
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_io_addr = a;
        o_io_wdata = d;
        o_io_wr = 1'b1;
        @(negedge i_sys_clk);
        o_io_wr = 1'b0;
        o_io_wdata = ~d;
    endtask
    // one read cycle, data taken the cycle after
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_io_addr = a;
        o_io_rd = 1'b1;
        @(negedge i_sys_clk);
        o_io_rd = 1'b0;
        d = i_io_rdata;
    endtask
    // load data, arm, then start the write
    task automatic byte_write(input logic [7:0] d);
        io_write(`EEBA_OFS_DATA, d);
        io_write(`EEBA_OFS_CTRL, 8'h04);
        io_write(`EEBA_OFS_CTRL, 8'h02);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self checking bench for the eeprom byte access block
`include "eeba_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [5:0] i_io_addr;
    logic [7:0] i_io_wdata, o_io_rdata, rd;
    logic i_io_wr, i_io_rd, o_cpu_stall, o_write_busy;
    int fails = 0;
    int n_checks = 0;
    int n;
    eeba_top eeba_top_inst (.i_sys_clk, .i_resetn, .i_io_addr, .i_io_wdata, .i_io_wr,
        .i_io_rd, .o_io_rdata, .o_cpu_stall, .o_write_busy);
    eeba_cpu_model cpu (.i_sys_clk, .i_io_rdata(o_io_rdata), .o_io_addr(i_io_addr),
        .o_io_wdata(i_io_wdata), .o_io_wr(i_io_wr), .o_io_rd(i_io_rd));
    // clock
    initial
    begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // count stall cycles over a fixed window
    task automatic stalls();
        n = 0;
        repeat (8)
        begin
            if (o_cpu_stall === 1'b1)
                n++;
            @(negedge i_sys_clk);
        end
    endtask
    // bounded wait for the self timed write
    task automatic wait_idle();
        n = 0;
        while (o_write_busy !== 1'b0 && n < 300)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        if (o_write_busy !== 1'b0)
        begin
            fails++;
            end_of_test();
        end
    endtask
    // read byte at current address, expect value and four stall cycles
    task automatic read_byte(input logic [7:0] exp);
        cpu.io_write(`EEBA_OFS_CTRL, 8'h01);
        stalls();
        check(8'(n), 8'h04);
        cpu.io_read(`EEBA_OFS_DATA, rd);
        check(rd, exp);
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        check({6'h00, o_cpu_stall, o_write_busy}, 8'h00);
        cpu.io_write(`EEBA_OFS_ADDR_LOW, 8'h34);
        cpu.io_write(`EEBA_OFS_ADDR_HIGH, 8'hF5);
        cpu.io_read(`EEBA_OFS_ADDR_HIGH, rd);
        check(rd, 8'h05);
        cpu.io_read(`EEBA_OFS_ADDR_LOW, rd);
        check(rd, 8'h34);
        cpu.byte_write(8'hA5);
        stalls();
        check(8'(n), 8'h02);
        cpu.io_read(`EEBA_OFS_CTRL, rd);
        check(rd & 8'h02, 8'h02);
        cpu.io_write(`EEBA_OFS_CTRL, 8'h01);
        stalls();
        check(8'(n), 8'h00);
        wait_idle();
        cpu.io_read(`EEBA_OFS_CTRL, rd);
        check(rd & 8'h02, 8'h00);
        cpu.io_write(`EEBA_OFS_ADDR_LOW, 8'h35);
        cpu.byte_write(8'h5A);
        wait_idle();
        cpu.io_write(`EEBA_OFS_DATA, 8'hC3);
        cpu.io_write(`EEBA_OFS_CTRL, 8'h02);
        check({7'h00, o_write_busy}, 8'h00);
        cpu.io_write(`EEBA_OFS_CTRL, 8'h04);
        cpu.io_read(`EEBA_OFS_CTRL, rd);
        check(rd & 8'h08, 8'h08);
        repeat (4) @(negedge i_sys_clk);
        cpu.io_write(`EEBA_OFS_CTRL, 8'h02);
        repeat (2) @(negedge i_sys_clk);
        check({7'h00, o_write_busy}, 8'h00);
        read_byte(8'h5A);
        cpu.io_write(`EEBA_OFS_ADDR_LOW, 8'h34);
        read_byte(8'hA5);
        end_of_test();
    end
endmodule
`default_nettype wire
